// *** logic/dnoc_pkg.sv ***
// Shared constants, register map and state types of the nominal termination control block.
package dnoc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_PS       = 40000;  // Core clock period, 25 MHz.
  localparam int ASYNC_DELAY_MIN_PS  = 2000;   // Shortest asynchronous switching delay.
  localparam int ASYNC_DELAY_MAX_PS  = 8500;   // Longest asynchronous switching delay.
  // Least time rounds up to whole cycles, never below one cycle.
  localparam int ASYNC_DELAY_CYCLES_RAW = (ASYNC_DELAY_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ASYNC_DELAY_CYCLES = (ASYNC_DELAY_CYCLES_RAW < 1) ? 1 : ASYNC_DELAY_CYCLES_RAW;
  localparam logic [2:0] MIN_HIGH_CHOP4  = 3'h4;  // Least high time after assert or chop-4 write.
  localparam logic [2:0] MIN_HIGH_BURST8 = 3'h6;  // Least high time after burst-8 write.
  localparam logic [4:0] LATENCY_OFFSET  = 5'h02; // Subtracted from write plus additive latency.
  localparam int         DELAY_DEPTH     = 32;    // Stages of the synchronous latency line.

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_EVENT  = 4'h8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Control word field positions.
  localparam int CTRL_CODE_LSB   = 0;   // Nominal termination code, 3 bits.
  localparam int CTRL_WRT_LSB    = 3;   // Write termination code, 2 bits.
  localparam int CTRL_INIT_BIT   = 5;   // Device initialised and calibrated.
  localparam int CTRL_DLLOFF_BIT = 6;   // DLL off or synchronising: asynchronous mode.
  localparam int CTRL_DLLDIS_BIT = 7;   // DLL disable mode: termination unsupported.
  localparam int CTRL_SREF_BIT   = 8;   // Self refresh.
  localparam int CTRL_CWL_LSB    = 9;   // Write latency, 4 bits.
  localparam int CTRL_AL_LSB     = 13;  // Additive latency, 4 bits.

  // Event word: sticky flags, write one to clear.
  localparam int EVT_HIGHTIME_BIT = 0;  // Control input dropped before its least high time.
  localparam int EVT_RESTRICT_BIT = 1;  // Restricted nominal strength used during a write.

  // ****************************************************************
  // Termination codes and strengths
  // ****************************************************************
  localparam logic [2:0] CODE_OFF      = 3'h0;
  localparam logic [2:0] CODE_DIV4     = 3'h1;
  localparam logic [2:0] CODE_DIV2     = 3'h2;
  localparam logic [2:0] CODE_DIV6     = 3'h3;
  localparam logic [2:0] CODE_DIV12    = 3'h4;
  localparam logic [2:0] CODE_DIV8     = 3'h5;
  localparam logic [7:0] REF_OHMS      = 8'hf0;  // Calibration reference resistance, 240 ohm.
  localparam logic [1:0] WRT_DISABLED  = 2'h0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0001,  // Reset, before initialisation, or DLL disabled.
    ST_SYNC    = 4'b0010,  // Latency-timed switching.
    ST_ASYNC   = 4'b0100,  // Fixed-delay switching while the DLL is off.
    ST_SELFREF = 4'b1000   // Self refresh, control input ignored.
  } dnoc_state_type;

  // Control word unpacked for use by the core logic.
  typedef struct packed {
    logic [3:0] additiveLatency;
    logic [3:0] writeLatency;
    logic       selfRefresh;
    logic       dllDisabled;
    logic       dllOff;
    logic       initDone;
    logic [1:0] writeCode;
    logic [2:0] nominalCode;
  } dnoc_ctrl_type;

  // Termination outputs bundled for the memory pad drivers.
  typedef struct packed {
    logic       on;           // Termination connected.
    logic       writeSelect;  // Write termination strength selected.
    logic [1:0] writeCode;    // Write termination code in use.
    logic [7:0] nominalOhms;  // Nominal termination value in ohms.
  } dnoc_term_type;

endpackage

// *** logic/dnoc_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for inputs from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module dnoc_pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic ce,
  input  wire logic pinIn,
  output logic      levelOut
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic stage1;  // Metastable stage, read only by stage2.
    logic stage2;
    logic stage3;
    logic level;   // Filtered level.
  } dnoc_sync_type;

  dnoc_sync_type sync_reg;
  dnoc_sync_type sync_next;

  // A change counts only once the second and third stages agree.
  always_comb begin
    sync_next        = sync_reg;
    sync_next.stage1 = pinIn;
    sync_next.stage2 = sync_reg.stage1;
    sync_next.stage3 = sync_reg.stage2;
    if (sync_reg.stage2 == sync_reg.stage3) begin
      sync_next.level = sync_reg.stage3;
    end
  end

  // Register the state; the clock enable freezes all of it.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync_reg <= {4{RESET_LEVEL}};
    end else if (ce) begin
      sync_reg <= sync_next;
    end
  end

  assign levelOut = sync_reg.level;

endmodule
`default_nettype wire

// *** logic/dnoc_latency_line.sv ***
// Shift line that delays the registered control level by a programmable cycle count.
`timescale 1ns/1ps
`default_nettype none

module dnoc_latency_line (
  input  wire logic       core_clk,
  input  wire logic       srst,
  input  wire logic       ce,
  input  wire logic       levelIn,
  input  wire logic [4:0] latency,
  output logic            levelOut
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Stage k holds the level registered k cycles ago.
  typedef struct packed {
    logic [dnoc_pkg::DELAY_DEPTH-1:0] line;
  } dnoc_line_type;

  dnoc_line_type line_reg;
  dnoc_line_type line_next;

  // Shift one place per enabled cycle.
  always_comb begin
    line_next.line = {line_reg.line[dnoc_pkg::DELAY_DEPTH-2:0], levelIn};
  end

  // Reset empties the line so nothing stale turns termination on.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_reg <= '0;
    end else if (ce) begin
      line_reg <= line_next;
    end
  end

  // The tap is picked by index; the caller keeps the latency below the depth.
  assign levelOut = line_reg.line[latency];

endmodule
`default_nettype wire

// *** logic/dnoc_odt_control.sv ***
// Nominal on-die termination control with its Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none

module dnoc_odt_control (
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          odtPin,           // Termination control pin from the controller.
  input  wire logic          resetPinN,        // Device reset pin, active low.
  input  wire logic          writeCmd,         // One-cycle pulse: write command registered.
  input  wire logic          writeIsBurst8,    // With writeCmd: burst-8, else chop-4.
  input  wire logic          writeBurst,       // Level: write data burst in progress.
  input  wire logic [3:0]    avsAddress,
  input  wire logic          avsRead,
  input  wire logic          avsWrite,
  input  wire logic [31:0]   avsWriteData,
  input  wire logic [3:0]    avsByteEnable,
  output logic [31:0]        avsReadData,
  output logic               avsWaitRequest,
  output dnoc_pkg::dnoc_term_type termOut
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Synchronous latency in cycles, clamped into the delay line.
  function automatic logic [4:0] syncLatency(input logic [3:0] write_latency, input logic [3:0] al);
    logic [4:0] sum;
    sum = {1'b0, write_latency} + {1'b0, al};
    if (sum < dnoc_pkg::LATENCY_OFFSET) begin
      syncLatency = 5'h00;
    end else begin
      syncLatency = sum - dnoc_pkg::LATENCY_OFFSET;
    end
  endfunction

  // Nominal strength in ohms for each legal code, zero when off or reserved.
  function automatic logic [7:0] nominalOhms(input logic [2:0] code);
    unique case (code)
      dnoc_pkg::CODE_DIV2:  nominalOhms = dnoc_pkg::REF_OHMS / 8'h02;
      dnoc_pkg::CODE_DIV4:  nominalOhms = dnoc_pkg::REF_OHMS / 8'h04;
      dnoc_pkg::CODE_DIV6:  nominalOhms = dnoc_pkg::REF_OHMS / 8'h06;
      dnoc_pkg::CODE_DIV8:  nominalOhms = dnoc_pkg::REF_OHMS / 8'h08;
      dnoc_pkg::CODE_DIV12: nominalOhms = dnoc_pkg::REF_OHMS / 8'h0c;
      default:              nominalOhms = 8'h00;
    endcase
  endfunction

  // Merge a bus write into a word under its byte enables.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] be);
    mergeBytes = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        mergeBytes[i*8 +: 8] = data[i*8 +: 8];
      end
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and latency line
  // ****************************************************************
  logic odtLevel;       // Filtered control pin level.
  logic resetLevelN;    // Filtered reset pin level.
  logic odtGated;       // Control level after ignore conditions.
  logic odtDelayed;     // Control level after the synchronous latency.

  // The control pin is registered on the rising edge only.
  dnoc_pin_sync #(.RESET_LEVEL(1'b0)) odtSync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .pinIn    (odtPin),
    .levelOut (odtLevel)
  );

  // Reset pin starts asserted so termination stays off until it is seen high.
  dnoc_pin_sync #(.RESET_LEVEL(1'b0)) rstSync (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .pinIn    (resetPinN),
    .levelOut (resetLevelN)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    dnoc_pkg::dnoc_state_type state;
    logic [31:0]              ctrlWord;     // Software control word.
    logic                     termOn;       // Termination connected.
    logic                     writeSelect;  // Write termination in use.
    logic [7:0]               ohms;         // Nominal value reported to the pads.
    logic                     asyncStage;   // Asynchronous path one-cycle delay.
    logic                     odtPrev;      // Control level one cycle ago.
    logic [2:0]               highCount;    // Cycles high since the last start point.
    logic [2:0]               highMin;      // Least high time now owed.
    logic                     evtHighTime;  // Sticky high time violation.
    logic                     evtRestrict;  // Sticky restricted strength during a write.
    logic                     ack;          // Bus answer cycle.
    logic [31:0]              readData;     // Registered read data.
  } dnoc_core_type;

  dnoc_core_type core_reg;
  dnoc_core_type core_next;

  dnoc_pkg::dnoc_ctrl_type ctrl;
  assign ctrl = dnoc_pkg::dnoc_ctrl_type'(core_reg.ctrlWord[16:0]);

  // ****************************************************************
  // Combinational decode
  // ****************************************************************
  logic codeIllegal;   // Reserved nominal code programmed.
  logic nominalOn;     // Nominal termination enabled by its code.
  logic dynamicOn;     // Write termination enabled by its code.
  logic anyEnabled;    // Some termination enabled at all.
  logic accepted;      // Bus request completes this cycle.

  always_comb begin
    codeIllegal = (ctrl.nominalCode > dnoc_pkg::CODE_DIV8);
    nominalOn   = (ctrl.nominalCode != dnoc_pkg::CODE_OFF) && !codeIllegal;
    dynamicOn   = (ctrl.writeCode != dnoc_pkg::WRT_DISABLED);
    anyEnabled  = nominalOn || dynamicOn;
    accepted    = (avsRead || avsWrite) && core_reg.ack;
  end

  // In self refresh or with all termination disabled the pin is ignored.
  assign odtGated = odtLevel && anyEnabled && (core_reg.state != dnoc_pkg::ST_SELFREF);

  // Latency measured from the registration edge of the control level.
  dnoc_latency_line latLine (
    .core_clk (core_clk),
    .srst     (srst),
    .ce       (ce),
    .levelIn  (odtGated),
    .latency  (syncLatency(ctrl.writeLatency, ctrl.additiveLatency)),
    .levelOut (odtDelayed)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One process computes the whole next state: mode, termination, checks and bus.
  always_comb begin
    core_next = core_reg;

    // Mode selection. Reset pin and missing initialisation win over everything.
    unique case (core_reg.state)
      dnoc_pkg::ST_OFF,
      dnoc_pkg::ST_SYNC,
      dnoc_pkg::ST_ASYNC,
      dnoc_pkg::ST_SELFREF: begin
        if (!resetLevelN || !ctrl.initDone || ctrl.dllDisabled) begin
          core_next.state = dnoc_pkg::ST_OFF;
        end else if (ctrl.selfRefresh) begin
          core_next.state = dnoc_pkg::ST_SELFREF;
        end else if (ctrl.dllOff) begin
          core_next.state = dnoc_pkg::ST_ASYNC;
        end else begin
          core_next.state = dnoc_pkg::ST_SYNC;
        end
      end
    endcase

    // The asynchronous path waits its fixed delay of one cycle; a longer
    // least delay would need more stages, which this clock rate never asks for.
    core_next.asyncStage = odtGated;

    // Termination switching by mode. The output register adds the half-cycle
    // completion skew, rounded to one whole cycle at this clock rate.
    unique case (core_reg.state)
      dnoc_pkg::ST_SYNC: begin
        core_next.termOn = odtDelayed;
      end
      dnoc_pkg::ST_ASYNC: begin
        core_next.termOn = core_reg.asyncStage;
      end
      dnoc_pkg::ST_OFF,
      dnoc_pkg::ST_SELFREF: begin
        core_next.termOn = 1'b0;
      end
    endcase

    // Write termination only while a write burst runs; nominal otherwise.
    core_next.writeSelect = dynamicOn && writeBurst
                            && (core_reg.state != dnoc_pkg::ST_OFF);
    // Code 000 or a reserved code reports no nominal value.
    core_next.ohms = nominalOn ? nominalOhms(ctrl.nominalCode) : 8'h00;

    // Least high time bookkeeping: restart on a rising edge or on a write
    // registered while high; the device only reports a violation.
    core_next.odtPrev = odtLevel;
    if (odtLevel && !core_reg.odtPrev) begin
      core_next.highCount = 3'h1;
      core_next.highMin   = dnoc_pkg::MIN_HIGH_CHOP4;
    end else if (odtLevel && writeCmd) begin
      core_next.highCount = 3'h1;
      core_next.highMin   = writeIsBurst8 ? dnoc_pkg::MIN_HIGH_BURST8
                                          : dnoc_pkg::MIN_HIGH_CHOP4;
    end else if (odtLevel && core_reg.highCount < core_reg.highMin) begin
      core_next.highCount = core_reg.highCount + 3'h1;
    end

    // Sticky events: a clear by software loses to a set in the same cycle.
    if (avsWrite && accepted && avsAddress == dnoc_pkg::ADDR_EVENT && avsByteEnable[0]) begin
      if (avsWriteData[dnoc_pkg::EVT_HIGHTIME_BIT]) begin
        core_next.evtHighTime = 1'b0;
      end
      if (avsWriteData[dnoc_pkg::EVT_RESTRICT_BIT]) begin
        core_next.evtRestrict = 1'b0;
      end
    end
    if (!odtLevel && core_reg.odtPrev && core_reg.highCount < core_reg.highMin) begin
      core_next.evtHighTime = 1'b1;
    end
    // Without write termination only the /2, /4, /6 strengths suit writes.
    if (writeBurst && !dynamicOn && core_reg.termOn
        && (ctrl.nominalCode == dnoc_pkg::CODE_DIV8
            || ctrl.nominalCode == dnoc_pkg::CODE_DIV12)) begin
      core_next.evtRestrict = 1'b1;
    end

    // Bus slave: one wait cycle, then the answer. Writes land at the answer edge.
    core_next.ack = (avsRead || avsWrite) && !core_reg.ack;
    if (avsWrite && accepted && avsAddress == dnoc_pkg::ADDR_CTRL) begin
      core_next.ctrlWord = mergeBytes(core_reg.ctrlWord, avsWriteData, avsByteEnable);
    end
    core_next.readData = 32'h0000_0000;
    if (avsRead && !core_reg.ack) begin
      unique case (avsAddress)
        dnoc_pkg::ADDR_CTRL: begin
          core_next.readData = {14'h0000, core_reg.ctrlWord[17:0]};
        end
        dnoc_pkg::ADDR_STATUS: begin
          core_next.readData = {23'h000000, odtLevel, core_reg.state, codeIllegal,
                                (core_reg.state == dnoc_pkg::ST_ASYNC),
                                core_reg.writeSelect, core_reg.termOn};
        end
        dnoc_pkg::ADDR_EVENT: begin
          core_next.readData = {30'h0000_0000, core_reg.evtRestrict, core_reg.evtHighTime};
        end
        default: begin
          core_next.readData = 32'h0000_0000;        // Unmapped addresses read zero.
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset to fixed values; the clock enable freezes everything.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      core_reg          <= '0;
      core_reg.state    <= dnoc_pkg::ST_OFF;
      core_reg.ctrlWord <= dnoc_pkg::CTRL_RESET;
    end else if (ce) begin
      core_reg <= core_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Wait request is combinational so the bus sees the answer cycle at once.
  assign avsWaitRequest      = (avsRead || avsWrite) && !core_reg.ack;
  assign avsReadData         = core_reg.readData;
  // One assignment drives the whole bundle, so the output keeps a single driver.
  assign termOut = '{on:          core_reg.termOn,
                     writeSelect: core_reg.writeSelect,
                     writeCode:   core_reg.writeSelect ? ctrl.writeCode : 2'h0,
                     nominalOhms: core_reg.ohms};

endmodule
`default_nettype wire

// *** verification/dnoc_ctl_model.sv ***
// Memory controller model driving the termination pin and write commands.
`timescale 1ns/1ps
`default_nettype none
module dnoc_ctl_model (
  input  wire logic       core_clk,
  input  wire logic       startHigh,   // Pulse: begin one high period.
  input  wire logic [5:0] highCycles,  // Requested high time in cycles.
  input  wire logic       addWrite,    // Issue a write inside the period.
  input  wire logic       burst8,      // Burst-8 write, else chop-4.
  output logic            odtPin,
  output logic            writeCmd,
  output logic            writeIsBurst8,
  output logic            writeBurst
);
  logic [5:0] cnt = 6'h00;  // Cycles since the period began.
  logic [5:0] hold = 6'h00; // High time after the least-time floor.
  logic       act = 1'b0;   // A high period is running.
  wire  logic [5:0] floorLen = (addWrite && burst8) ? 6'h06 : 6'h04;
  // The pin never drops early, and stays low outside periods, so reads stay clean.
  always_ff @(posedge core_clk) begin
    if (startHigh) begin
      act <= 1'b1;
      cnt <= 6'h00;
      hold <= (highCycles > floorLen) ? highCycles : floorLen;
    end else if (act) begin
      cnt <= cnt + 6'h01;
      act <= (cnt + 6'h01) < hold;
    end
  end
  assign odtPin = act;
  assign writeCmd = act && addWrite && (cnt == 6'h00);
  // Outside the command the qualifier carries no value, so it shows the inverse.
  assign writeIsBurst8 = writeCmd ? burst8 : ~burst8;
  assign writeBurst = act && addWrite && (cnt >= 6'h04) && (cnt < 6'h0c);
endmodule
`default_nettype wire

// *** verification/dnoc_odt_control_chk.sv ***
// Concurrent checks on the ports of the termination control block.
`timescale 1ns/1ps
`default_nettype none
module dnoc_odt_control_chk (
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire logic                    odtPin,
  input wire logic                    resetPinN,
  input wire logic                    writeBurst,
  input wire logic                    avsRead,
  input wire logic                    avsWrite,
  input wire logic                    avsWaitRequest,
  input wire dnoc_pkg::dnoc_term_type termOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  logic [5:0] lowCnt_reg;  // Cycles the pin has stayed low, saturating.
  // Longest latency plus synchroniser stays under 40 cycles of low pin.
  always_ff @(posedge core_clk) begin
    if (srst || odtPin) begin
      lowCnt_reg <= 6'h00;
    end else if (lowCnt_reg != 6'h3f) begin
      lowCnt_reg <= lowCnt_reg + 6'h01;
    end
  end
  a_reset_clears: assert property ($fell(srst) |-> termOut == '0)
    else $error("termination not cleared by reset");
  a_first_wait: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest)
    else $error("request answered without a wait cycle");
  a_one_wait: assert property ((avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest)
    else $error("request not answered after one wait cycle");
  a_ohms_legal: assert property (termOut.nominalOhms inside {8'h00, 8'h78, 8'h3c, 8'h28,
    8'h1e, 8'h14})
    else $error("nominal strength outside the offered set");
  a_pin_low_off: assert property (lowCnt_reg >= 6'h28 |-> !termOut.on)
    else $error("termination on long after the pin fell");
  a_resetpin_off: assert property ($fell(resetPinN) |-> ##[1:12] !termOut.on)
    else $error("reset pin did not switch termination off");
  a_no_early_on: assert property ($rose(odtPin) && !termOut.on |-> !termOut.on [*4])
    else $error("termination on before the pin was registered");
  a_sel_in_burst: assert property ($rose(termOut.writeSelect) |-> $past(writeBurst))
    else $error("write strength selected outside a burst");
  a_sel_code: assert property (termOut.writeSelect |-> termOut.writeCode != 2'h0)
    else $error("write strength selected with write code off");
  c_on: cover property ($rose(termOut.on));
  c_sel: cover property ($rose(termOut.writeSelect));
  c_read: cover property (avsRead && !avsWaitRequest);
endmodule
bind dnoc_odt_control dnoc_odt_control_chk u_chk (.core_clk(core_clk), .srst(srst),
  .odtPin(odtPin), .resetPinN(resetPinN), .writeBurst(writeBurst), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWaitRequest(avsWaitRequest), .termOut(termOut));
`default_nettype wire

// *** verification/dnoc_odt_control_tb.sv ***
// Self-checking bench for the termination control block.
`timescale 1ns/1ps
`default_nettype none
module dnoc_odt_control_tb;
  logic core_clk = 1'b0, srst = 1'b1, resetPinN = 1'b1, ce = 1'b1;
  logic avsRead = 1'b0, avsWrite = 1'b0, startHigh = 1'b0, addWrite = 1'b0, burst8 = 1'b0;
  logic odtPin, writeCmd, writeIsBurst8, writeBurst, avsWaitRequest;
  logic [3:0] avsAddress = 4'h0, avsByteEnable = 4'hf;
  logic [5:0] highCycles = 6'h08;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
  dnoc_pkg::dnoc_term_type termOut;
  int failures = 0, checks_done = 0, cycles = 0, t1, o1, t2, o2, a, b;
  logic [9:0] s;  // Write code and nominal ohms seen in the last pulse.
  logic [7:0] ohms [1:5] = '{8'h3c, 8'h78, 8'h28, 8'h14, 8'h1e};
  logic [6:0] offCase [5] = '{7'h01, 7'h61, 7'h71, 7'h29, 7'h25};  // Code, flags.
  always #20 core_clk = ~core_clk;
  dnoc_odt_control DUT (.core_clk(core_clk), .srst(srst), .ce(ce), .odtPin(odtPin),
    .resetPinN(resetPinN), .writeCmd(writeCmd), .writeIsBurst8(writeIsBurst8),
    .writeBurst(writeBurst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .termOut(termOut));
  dnoc_ctl_model ctlModel (.core_clk(core_clk), .startHigh(startHigh), .highCycles(highCycles),
    .addWrite(addWrite), .burst8(burst8), .odtPin(odtPin), .writeCmd(writeCmd),
    .writeIsBurst8(writeIsBurst8), .writeBurst(writeBurst));
  // Control word: additive latency, write latency 5, flags, write code, nominal code.
  function automatic logic [31:0] ctl(input logic [2:0] c, input logic [1:0] w,
                                      input logic [3:0] f, input logic [3:0] al);
    return {15'h0, al, 4'h5, f, w, c};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask
  // One bus cycle, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
    avsAddress <= ad;
    avsWriteData <= wd;
    avsWrite <= wr;
    avsRead <= ~wr;
    do @(posedge core_clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    @(posedge core_clk);
  endtask
  // One pin pulse; records the on and off cycles and what was seen meanwhile.
  task automatic pulse(input logic [5:0] n, input logic w);
    a = 0;
    b = 0;
    s = 10'h0;
    startHigh <= 1'b1;
    highCycles <= n;
    addWrite <= w;
    burst8 <= w;
    @(posedge core_clk);
    startHigh <= 1'b0;
    for (int i = 1; i <= 80; i++) begin
      @(posedge core_clk);
      if (termOut.on === 1'b1 && a == 0) begin
        a = i;
        s[7:0] = termOut.nominalOhms;
      end
      if (termOut.on !== 1'b1 && a != 0 && b == 0) b = i;
      if (termOut.writeSelect === 1'b1) s[9:8] = termOut.writeCode;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hang counts as a mismatch and goes to the closing report.
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check(32'(termOut), 32'h0);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, dnoc_pkg::ADDR_CTRL, 32'h0);
    check(rd, dnoc_pkg::CTRL_RESET);
    bus(1'b0, 4'hc, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'h2, 2'h0, 4'h0, 4'h0));
    pulse(6'h08, 1'b0);
    check(32'(a), 32'h0);
    $display("reset test done");
    for (int k = 1; k <= 5; k++) begin
      bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'(k), 2'h0, 4'h1, 4'h0));
      pulse(6'h08, 1'b0);
      check({22'h0, s}, {24'h0, ohms[k]});
    end
    t1 = a;
    o1 = b;
    bus(1'b0, dnoc_pkg::ADDR_CTRL, 32'h0);
    check(rd, ctl(3'h5, 2'h0, 4'h1, 4'h0));
    bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'h5, 2'h0, 4'h1, 4'h4));
    pulse(6'h08, 1'b0);
    check(32'(a - t1), 32'h4);
    check(32'(b - o1), 32'h4);
    bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'h5, 2'h0, 4'h3, 4'h0));
    pulse(6'h08, 1'b0);
    check(32'(t1 - a), 32'h3);
    check(32'(o1 - b), 32'h3);
    bus(1'b0, dnoc_pkg::ADDR_STATUS, 32'h0);
    check(rd, 32'h44);
    $display("latency test done");
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(offCase[k][6:4], 2'h0, offCase[k][3:0], 4'h0));
      pulse(6'h08, 1'b0);
      check(32'(a), 32'h0);
    end
    bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'h2, 2'h1, 4'h1, 4'h0));
    pulse(6'h10, 1'b1);
    check({22'h0, s}, 32'h178);
    bus(1'b1, dnoc_pkg::ADDR_CTRL, ctl(3'h4, 2'h0, 4'h1, 4'h0));
    pulse(6'h10, 1'b1);
    bus(1'b0, dnoc_pkg::ADDR_EVENT, 32'h0);
    check(rd, 32'h2);
    resetPinN <= 1'b0;
    pulse(6'h08, 1'b0);
    check(32'(a), 32'h0);
    $display("gating test done");
    give_verdict();
  end
endmodule
`default_nettype wire
